//--- core/pdm_mux.sv
// What this block does
// - Mode pin high gives the data pins to the external memory path.
// - Mode pin low makes the pins a 16-bit host data bus to memory.
// - Undriven pins keep their last driven level while the holder is enabled.
// - Holder disabled at reset; only the control register holder bit changes it.
// - Output-disable pin low puts every data pin in high impedance.
//
// Purpose: Steers the 16-bit parallel data pins between memory and host paths.
// Assumes: Mode and disable pins are asynchronous; internal requests share clk_sys_i.
// Notes: Each pin is input, output value and output enable; the pad resolves it.
`timescale 1ns/1ps
module pdm_mux #(
   parameter int DATA_W = pdm_pkg::PDM_DATA_W
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic port_mode_select_i,
   input wire logic output_disable_b_i,
   input wire logic bus_holder_enable_wr_i,
   input wire logic bus_holder_enable_i,
   input wire pdm_pkg::pdm_req_t ext_memory_req_i,
   input wire pdm_pkg::pdm_req_t host_port_req_i,
   input wire logic [DATA_W-1:0] parallel_data_pins_i,
   output logic [DATA_W-1:0] parallel_data_pins_o,
   output logic [DATA_W-1:0] parallel_data_pins_oe_o,
   output logic [DATA_W-1:0] rd_data_o,
   output logic mode_o,
   output logic bus_holder_enable_o
);
   import pdm_pkg::*;

   logic mode_sync;
   logic off_b_sync;
   logic [DATA_W-1:0] pin_sync;
   pdm_mode_t mode;
   pdm_req_t sel_req;
   logic drive_w;
   logic hold_w;
   logic [DATA_W-1:0] last_reg;
   logic [DATA_W-1:0] last_next;
   logic holder_reg;
   logic [DATA_W-1:0] out_reg;
   logic [DATA_W-1:0] oe_reg;
   logic [DATA_W-1:0] rd_reg;
   logic mode_reg;

   // Mode and disable pins are asynchronous, so both pass two flops first.
   pdm_sync #(
      .WIDTH(2),
      .RST_VAL({PDM_MODE_RST, 1'b0})
   ) u_ctl_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .async_i({port_mode_select_i, output_disable_b_i}),
      .sync_o({mode_sync, off_b_sync})
   );

   // Pin readback is also off-domain.
   pdm_sync #(
      .WIDTH(DATA_W),
      .RST_VAL(DATA_W'(PDM_DATA_RST))
   ) u_pin_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .async_i(parallel_data_pins_i),
      .sync_o(pin_sync)
   );

   // The mode is only sampled; a clean switch relies on the host idling first.
   assign mode = mode_sync ? PDM_EXT_MEMORY : PDM_HOST_PORT;
   assign sel_req = (mode == PDM_EXT_MEMORY) ? ext_memory_req_i : host_port_req_i;
   // Disable overrides every other source of drive.
   assign drive_w = off_b_sync && sel_req.drive;
   assign hold_w = off_b_sync && !sel_req.drive && holder_reg;
   assign last_next = drive_w ? sel_req.data[DATA_W-1:0] : last_reg;

   // Holder bit: cleared by reset, changed only by the register write strobe.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         holder_reg <= PDM_HOLD_EN_RST;
      end else if (ce_i && bus_holder_enable_wr_i) begin
         holder_reg <= bus_holder_enable_i;
      end
   end

   // Remember the last driven level so the keeper can replay it.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         last_reg <= DATA_W'(PDM_DATA_RST);
      end else if (ce_i) begin
         last_reg <= last_next;
      end
   end

   // Registered pin drive; keeper drive is modelled as a weak-equivalent enable.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         out_reg <= DATA_W'(PDM_DATA_RST);
         oe_reg <= '0;
      end else if (ce_i) begin
         out_reg <= last_next;
         oe_reg <= {DATA_W{drive_w || hold_w}};
      end
   end

   // Status and read path toward the internal requesters.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         rd_reg <= DATA_W'(PDM_DATA_RST);
         mode_reg <= PDM_MODE_RST;
      end else if (ce_i) begin
         rd_reg <= pin_sync;
         mode_reg <= mode_sync;
      end
   end

   assign parallel_data_pins_o = out_reg;
   assign parallel_data_pins_oe_o = oe_reg;
   assign rd_data_o = rd_reg;
   assign mode_o = mode_reg;
   assign bus_holder_enable_o = holder_reg;

   // Disable pin low (after sync) means no pin driven next cycle.
   a_off_no_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (ce_i && !off_b_sync) |=> (parallel_data_pins_oe_o == '0))
      else $error("Pins driven while disabled.");

   // Holder comes out of reset off.
   a_holder_reset: assert property (@(posedge clk_sys_i)
      !rst_b_i |=> !bus_holder_enable_o)
      else $error("Holder not cleared by reset.");

   // Holder changes only on a write strobe.
   a_holder_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (!bus_holder_enable_wr_i && $past(rst_b_i)) |=> $stable(bus_holder_enable_o))
      else $error("Holder bit changed without write.");

   // Memory mode forwards the memory path data.
   a_ext_mem_data: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (ce_i && off_b_sync && mode_sync && ext_memory_req_i.drive)
      |=> (parallel_data_pins_oe_o == '1 && parallel_data_pins_o == $past(ext_memory_req_i.data)))
      else $error("Memory path not on pins.");

   // Host mode forwards the host path data.
   a_host_data: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (ce_i && off_b_sync && !mode_sync && host_port_req_i.drive)
      |=> (parallel_data_pins_oe_o == '1 && parallel_data_pins_o == $past(host_port_req_i.data)))
      else $error("Host path not on pins.");

   // Idle with holder on replays the previous level.
   a_keep_level: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (ce_i && off_b_sync && !sel_req.drive && holder_reg)
      |=> (parallel_data_pins_oe_o == '1 && $stable(parallel_data_pins_o)))
      else $error("Holder lost the last level.");

   // Idle with holder off leaves pins floating.
   a_float_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (ce_i && !sel_req.drive && !holder_reg) |=> (parallel_data_pins_oe_o == '0))
      else $error("Pins driven while idle with holder off.");

   // Disable beats a holder that is on and a requester that drives.
   a_off_priority: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (ce_i && !off_b_sync && (holder_reg || sel_req.drive)) |=> (parallel_data_pins_oe_o == '0))
      else $error("Disable lost priority.");

   // Reset leaves every pin released, whatever the requesters do.
   a_reset_release: assert property (@(posedge clk_sys_i)
      !rst_b_i |=> (parallel_data_pins_oe_o == '0))
      else $error("Pins driven right after reset.");

   // A holder write lands one edge later with the written value.
   a_holder_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (ce_i && bus_holder_enable_wr_i) |=> (bus_holder_enable_o == $past(bus_holder_enable_i)))
      else $error("Holder write lost.");

   // The reported mode follows the synchronised mode pin by one edge.
   a_mode_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      ce_i |=> (mode_o == $past(mode_sync)))
      else $error("Mode report wrong.");

   // Read data is the synchronised pin level one edge later.
   a_read_path: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      ce_i |=> (rd_data_o == $past(pin_sync)))
      else $error("Read path wrong.");

   // A low clock enable must freeze the pads and the holder bit.
   a_ce_freeze: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !ce_i |=> ($stable(parallel_data_pins_oe_o) && $stable(parallel_data_pins_o)
                 && $stable(bus_holder_enable_o)))
      else $error("State moved with clock enable low.");

   // A driven word followed by an idle cycle with the keeper on must replay that word.
   // The two steps are separate sequences so each can be read on its own.
   sequence s_word_driven;
      ce_i && drive_w;
   endsequence

   sequence s_keeper_on;
      ce_i && hold_w;
   endsequence

   a_keep_word: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      s_word_driven ##1 s_keeper_on |=> (parallel_data_pins_o == $past(sel_req.data, 2)))
      else $error("Keeper replayed the wrong word.");
endmodule : pdm_mux

//--- core/pdm_pkg.sv
// Purpose: Shared types and constants for the parallel data bus pin mux.
// Assumes: One 25 MHz system clock, synchronous active-low reset.
// Notes: Pin-side signals travel as packed structs.
package pdm_pkg;

   localparam int PDM_DATA_W = 16;
   localparam int PDM_SYNC_STAGES = 2;
   localparam logic PDM_HOLD_EN_RST = 1'b0;
   localparam logic [PDM_DATA_W-1:0] PDM_DATA_RST = 16'h0000;
   localparam logic PDM_MODE_RST = 1'b0;

   // Which internal path owns the pins.
   typedef enum logic {
      PDM_HOST_PORT,
      PDM_EXT_MEMORY
   } pdm_mode_t;

   // One internal requester's view of the pins.
   typedef struct packed {
      logic drive;
      logic [PDM_DATA_W-1:0] data;
   } pdm_req_t;

   // What the block presents at the three-signal pin port.
   typedef struct packed {
      logic [PDM_DATA_W-1:0] oe;
      logic [PDM_DATA_W-1:0] data;
      logic [PDM_DATA_W-1:0] keep_oe;
   } pdm_pins_t;

endpackage : pdm_pkg

//--- core/pdm_sync.sv
// Purpose: Two-flop synchroniser for asynchronous pin levels.
// Assumes: The first stage is read by the second stage only.
// Notes: Width is a parameter so the data pins and control pins share one cell.
`timescale 1ns/1ps
module pdm_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // Reset value is a parameter, so the reset branch loads constants only.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else if (ce_i) begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;
endmodule : pdm_sync

//--- sim/pdm_far_end.sv
// Purpose: Far-side memory or host model that shares the parallel data pins.
// Assumes: The device side hands over pad value and enable per pin.
// Notes: A released line toggles each cycle, so a held level is never faked.
`timescale 1ns/1ps
module pdm_far_end (
   input wire logic clk_sys_i,
   input wire logic [15:0] dev_o_i,
   input wire logic [15:0] dev_oe_i,
   input wire logic drive_i,
   input wire logic [15:0] data_i,
   output logic [15:0] pins_o
);
   logic [15:0] last_reg = 16'h0000;
   // Resolve each pin; the far side only drives pins the device has let go.
   always_comb begin
      for (int b = 0; b < 16; b++) begin
         if (dev_oe_i[b]) pins_o[b] = dev_o_i[b];
         else if (drive_i) pins_o[b] = data_i[b];
         else pins_o[b] = ~last_reg[b];
      end
   end
   // Keep the last level per cycle so an undriven pin keeps moving.
   always @(posedge clk_sys_i) last_reg <= pins_o;
endmodule : pdm_far_end

//--- sim/pdm_mux_tb.sv
// Purpose: Self-checking bench for the parallel data pin mux.
// Assumes: The mode and disable pins settle after three edges.
// Notes: Requests go idle before every mode change.
`timescale 1ns/1ps
module pdm_mux_tb;
   import pdm_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic mode = 1'b0, off_b = 1'b0, wr = 1'b0, hold = 1'b0, far_drv = 1'b0, mode_q, hold_q;
   pdm_req_t ext = '0, host = '0;
   logic [15:0] far_data = 16'h0000, pins, o, oe, rd, last = 16'h0000, frz_oe, frz_o;
   logic ce = 1'b1, frz_hold;
   logic [31:0] seed = 32'hc73f038e, r;
   int fails = 0, check_count = 0;
   always #20 clk_sys_i = ~clk_sys_i;
   pdm_mux pdm_mux_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce),
      .port_mode_select_i(mode), .output_disable_b_i(off_b), .bus_holder_enable_wr_i(wr),
      .bus_holder_enable_i(hold), .ext_memory_req_i(ext), .host_port_req_i(host),
      .parallel_data_pins_i(pins), .parallel_data_pins_o(o), .parallel_data_pins_oe_o(oe),
      .rd_data_o(rd), .mode_o(mode_q), .bus_holder_enable_o(hold_q));
   pdm_far_end pdm_far_end_i (.clk_sys_i(clk_sys_i), .dev_o_i(o), .dev_oe_i(oe),
      .drive_i(far_drv), .data_i(far_data), .pins_o(pins));
   // Xorshift source keeps random runs repeatable.
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic check(input logic [16:0] got, input logic [16:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask : tick
   // Set mode with the bus idle, then request, then compare the pads.
   task automatic apply(input logic m, d, h, input pdm_req_t er, hr, input logic fd);
      logic drv;
      logic [15:0] e_oe;
      ext = '0;
      host = '0;
      mode = m;
      off_b = d;
      hold = h;
      wr = 1'b1;
      far_drv = 1'b0;
      tick(1);
      wr = 1'b0;
      tick(2);
      ext = er;
      host = hr;
      far_drv = fd;
      far_data = xs();
      tick(1);
      drv = m ? er.drive : hr.drive;
      e_oe = (d && (drv || h)) ? 16'hffff : 16'h0000;
      check(oe, e_oe);
      if (drv && d) last = m ? er.data : hr.data;
      if (e_oe != 0) check(o, last);
      check({hold_q, mode_q}, {h, m});
      if (e_oe == 0 && fd) begin
         tick(3);
         check(rd, far_data);
      end
      $display("test done mode %0b off_b %0b hold %0b", m, d, h);
   endtask : apply
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   // Watchdog allows several times the expected run.
   initial begin
      #80000;
      fails++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk_sys_i);
      #1;
      rst_b_i = 1'b1;
      check(oe, 16'h0000);
      apply(1'b1, 1'b1, 1'b0, {1'b1, 16'h1234}, {1'b1, 16'h5678}, 1'b0);
      apply(1'b0, 1'b1, 1'b0, {1'b1, 16'h8001}, {1'b1, 16'habcd}, 1'b0);
      apply(1'b0, 1'b1, 1'b1, '0, '0, 1'b1);
      apply(1'b1, 1'b1, 1'b0, '0, '0, 1'b1);
      apply(1'b1, 1'b0, 1'b1, {1'b1, 16'hffff}, '0, 1'b0);
      for (int i = 0; i < 40; i++) begin
         r = xs();
         apply(r[0], r[1] | r[2], r[3], {r[4], r[31:16]}, {r[5], ~r[31:16]}, r[6]);
      end
      // Clock enable low: new requests and a holder write must not move anything.
      {frz_hold, frz_oe, frz_o} = {hold_q, oe, o};
      ce = 1'b0;
      wr = 1'b1;
      hold = ~hold_q;
      ext = {1'b1, ~o};
      host = {1'b1, ~o};
      tick(3);
      check(oe, frz_oe);
      check(o, frz_o);
      check(hold_q, frz_hold);
      ce = 1'b1;
      wr = 1'b0;
      ext = '0;
      host = '0;
      tick(1);
      $display("test done clock enable freeze");
      end_sim();
   end
endmodule : pdm_mux_tb
